// file: rtl/dtx_addr_unit.sv
// dtx_addr_unit: effective address and pointer update for one transfer
`timescale 1ns/1ps
module dtx_addr_unit (
  input wire logic [15:0] ptr,
  input wire dtx_pkg::dtx_mode_t mode,
  input wire logic use_disp,
  input wire logic [5:0] disp,
  output logic [15:0] eff_addr,
  output logic [15:0] ptr_next,
  output logic ptr_update
);
  import dtx_pkg::*;

  always_comb begin
    eff_addr = ptr;
    ptr_next = ptr;
    ptr_update = 1'b0;
    if (use_disp) begin
      eff_addr = ptr + {10'h000, disp};
    end else begin
      unique case (mode)
        DTX_AM_PLAIN: begin
          ptr_update = 1'b0;
        end
        DTX_AM_POST_INC: begin
          ptr_next = ptr + 16'h0001;
          ptr_update = 1'b1;
        end
        DTX_AM_PRE_DEC: begin
          ptr_next = ptr - 16'h0001;
          eff_addr = ptr_next;
          ptr_update = 1'b1;
        end
        default: begin
          ptr_update = 1'b0;
        end
      endcase
    end
  end
endmodule : dtx_addr_unit

// file: rtl/dtx_exec.sv
// dtx_exec: executes data transfer instructions against data and program memory
`timescale 1ns/1ps
module dtx_exec (
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire dtx_pkg::dtx_instr_t instr,
  output dtx_pkg::dtx_mem_req_t data_req,
  input wire logic [7:0] data_rdata,
  output logic [15:0] prog_addr,
  output logic prog_rd,
  input wire logic [7:0] prog_rdata,
  output logic done,
  output logic illegal,
  output logic [15:0] stack_ptr,
  input wire logic [4:0] peek_idx,
  output logic [7:0] peek_data
);
  import dtx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  dtx_state_t state;
  dtx_state_t next_state;
  dtx_instr_t cur;
  dtx_instr_t next_cur;
  logic [15:0] sp;
  logic [15:0] next_sp;
  dtx_mem_req_t next_data_req;
  logic [15:0] next_prog_addr;
  logic next_prog_rd;
  logic next_done;
  logic next_illegal;

  logic [4:0] ptr_base;
  logic [15:0] ptr_val;
  logic [7:0] src_data;
  logic [15:0] eff_addr;
  logic [15:0] ptr_next;
  logic ptr_update;
  logic use_disp;
  logic rf_wr_en;
  logic [4:0] rf_wr_idx;
  logic [7:0] rf_wr_data;
  logic ptr_wr_en;

  function automatic logic [4:0] dtx_ptr_base(input dtx_ptr_t sel);
    unique case (sel)
      DTX_PTR_SEL_X: return 5'(DTX_PTR_X);
      DTX_PTR_SEL_Y: return 5'(DTX_PTR_Y);
      default: return 5'(DTX_PTR_Z);
    endcase
  endfunction : dtx_ptr_base

  function automatic logic dtx_is_load(input dtx_op_t op);
    return op == DTX_OP_LOAD || op == DTX_OP_DISP_LOAD || op == DTX_OP_DIRECT_LOAD || op == DTX_OP_POP;
  endfunction : dtx_is_load

  ////////////////////////////////////////////////////////////////////////////
  // operand decode for the instruction held in cur
  always_comb begin
    ptr_base = dtx_ptr_base(cur.ptr);
    if (cur.op == DTX_OP_PROG_READ) begin
      ptr_base = 5'(DTX_PTR_Z);
    end
    use_disp = cur.op == DTX_OP_DISP_LOAD || cur.op == DTX_OP_DISP_STORE;
  end

  dtx_regfile u_regfile (
    .clk(clk),
    .rst(rst),
    .rd_idx(cur.reg_idx),
    .rd_data(src_data),
    .ptr_base(ptr_base),
    .ptr_data(ptr_val),
    .wr_en(rf_wr_en),
    .wr_idx(rf_wr_idx),
    .wr_data(rf_wr_data),
    .ptr_wr_en(ptr_wr_en),
    .ptr_wr_data(ptr_next),
    .peek_idx(peek_idx),
    .peek_data(peek_data)
  );

  dtx_addr_unit u_addr (
    .ptr(ptr_val),
    .mode(cur.mode),
    .use_disp(use_disp),
    .disp(cur.disp),
    .eff_addr(eff_addr),
    .ptr_next(ptr_next),
    .ptr_update(ptr_update)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: IDLE accepts, EXEC issues, WAIT for program memory, DONE writes back
  always_comb begin
    next_state = state;
    next_cur = cur;
    next_sp = sp;
    next_data_req = '0;
    next_prog_addr = prog_addr;
    next_prog_rd = 1'b0;
    next_done = 1'b0;
    next_illegal = 1'b0;
    rf_wr_en = 1'b0;
    rf_wr_idx = cur.reg_idx;
    rf_wr_data = data_rdata;
    ptr_wr_en = 1'b0;
    unique case (state)
      DTX_ST_IDLE: begin
        if (instr_valid) begin
          next_cur = instr;
          if ((instr.op == DTX_OP_DISP_LOAD || instr.op == DTX_OP_DISP_STORE) && instr.ptr == DTX_PTR_SEL_X) begin
            next_illegal = 1'b1;
            next_done = 1'b1;
          end else if (instr.op != DTX_OP_NONE) begin
            next_state = DTX_ST_EXEC;
          end
        end
      end
      DTX_ST_EXEC: begin
        unique case (cur.op)
          DTX_OP_LOAD, DTX_OP_DISP_LOAD: begin
            next_data_req.rd = 1'b1;
            next_data_req.addr = eff_addr;
            ptr_wr_en = ptr_update;
          end
          DTX_OP_STORE, DTX_OP_DISP_STORE: begin
            next_data_req.wr = 1'b1;
            next_data_req.addr = eff_addr;
            next_data_req.wdata = src_data;
            ptr_wr_en = ptr_update;
          end
          DTX_OP_DIRECT_LOAD: begin
            next_data_req.rd = 1'b1;
            next_data_req.addr = cur.addr;
          end
          DTX_OP_DIRECT_STORE: begin
            next_data_req.wr = 1'b1;
            next_data_req.addr = cur.addr;
            next_data_req.wdata = src_data;
          end
          DTX_OP_PUSH: begin
            next_data_req.wr = 1'b1;
            next_data_req.addr = sp;
            next_data_req.wdata = src_data;
            next_sp = sp - 16'h0001;
          end
          DTX_OP_POP: begin
            next_data_req.rd = 1'b1;
            next_data_req.addr = sp + 16'h0001;
            next_sp = sp + 16'h0001;
          end
          DTX_OP_PROG_READ: begin
            next_prog_rd = 1'b1;
            next_prog_addr = ptr_val;
            ptr_wr_en = ptr_update;
          end
          default: begin
            next_data_req = '0;
          end
        endcase
        next_state = cur.op == DTX_OP_PROG_READ ? DTX_ST_WAIT : DTX_ST_DONE;
      end
      DTX_ST_WAIT: begin
        next_state = DTX_ST_DONE;
      end
      DTX_ST_DONE: begin
        if (cur.op == DTX_OP_PROG_READ) begin
          rf_wr_en = 1'b1;
          rf_wr_data = prog_rdata;
        end else begin
          rf_wr_en = dtx_is_load(cur.op);
        end
        next_done = 1'b1;
        next_state = DTX_ST_IDLE;
      end
      default: begin
        next_state = DTX_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= DTX_ST_IDLE;
      cur <= '0;
      sp <= DTX_SP_RESET;
      data_req <= '0;
      prog_addr <= 16'h0000;
      prog_rd <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      sp <= next_sp;
      data_req <= next_data_req;
      prog_addr <= next_prog_addr;
      prog_rd <= next_prog_rd;
      done <= next_done;
      illegal <= next_illegal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign instr_ready = state == DTX_ST_IDLE;
  assign stack_ptr = sp;
endmodule : dtx_exec

// file: rtl/dtx_pkg.sv
// dtx_pkg: shared types and constants for the data transfer execution unit
package dtx_pkg;
  localparam int DTX_PTR_X = 26;
  localparam int DTX_PTR_Y = 28;
  localparam int DTX_PTR_Z = 30;
  localparam logic [4:0] DTX_REG_ZERO = 5'h00;
  localparam logic [15:0] DTX_SP_RESET = 16'h00DF;
  localparam logic [1:0] DTX_CYCLES_DATA = 2'h2;
  localparam logic [1:0] DTX_CYCLES_PROG = 2'h3;

  typedef enum logic [3:0] {
    DTX_OP_NONE = 4'h0,
    DTX_OP_LOAD = 4'h1,
    DTX_OP_STORE = 4'h2,
    DTX_OP_DISP_LOAD = 4'h3,
    DTX_OP_DISP_STORE = 4'h4,
    DTX_OP_DIRECT_LOAD = 4'h5,
    DTX_OP_DIRECT_STORE = 4'h6,
    DTX_OP_PROG_READ = 4'h7,
    DTX_OP_PUSH = 4'h8,
    DTX_OP_POP = 4'h9
  } dtx_op_t;

  typedef enum logic [1:0] {
    DTX_PTR_SEL_X = 2'h0,
    DTX_PTR_SEL_Y = 2'h1,
    DTX_PTR_SEL_Z = 2'h2
  } dtx_ptr_t;

  typedef enum logic [1:0] {
    DTX_AM_PLAIN = 2'h0,
    DTX_AM_POST_INC = 2'h1,
    DTX_AM_PRE_DEC = 2'h2
  } dtx_mode_t;

  typedef struct packed {
    dtx_op_t op;
    dtx_ptr_t ptr;
    dtx_mode_t mode;
    logic [4:0] reg_idx;
    logic [5:0] disp;
    logic [15:0] addr;
  } dtx_instr_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dtx_mem_req_t;

  typedef enum logic [1:0] {
    DTX_ST_IDLE = 2'b00,
    DTX_ST_EXEC = 2'b01,
    DTX_ST_WAIT = 2'b11,
    DTX_ST_DONE = 2'b10
  } dtx_state_t;
endpackage : dtx_pkg

// file: rtl/dtx_regfile.sv
// dtx_regfile: 32 by 8 working registers with a pair write port for pointers
`timescale 1ns/1ps
module dtx_regfile (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] rd_idx,
  output logic [7:0] rd_data,
  input wire logic [4:0] ptr_base,
  output logic [15:0] ptr_data,
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic ptr_wr_en,
  input wire logic [15:0] ptr_wr_data,
  input wire logic [4:0] peek_idx,
  output logic [7:0] peek_data
);
  logic [7:0] regs [32];
  logic [7:0] next_regs [32];

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      next_regs[i] = regs[i];
    end
    if (ptr_wr_en) begin
      next_regs[ptr_base] = ptr_wr_data[7:0];
      next_regs[ptr_base + 5'h01] = ptr_wr_data[15:8];
    end
    if (wr_en) begin
      next_regs[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < 32; i++) begin
      regs[i] <= rst ? 8'h00 : next_regs[i];
    end
  end

  assign rd_data = regs[rd_idx];
  assign peek_data = regs[peek_idx];
  assign ptr_data = {regs[ptr_base + 5'h01], regs[ptr_base]};
endmodule : dtx_regfile

// file: testbench/data_transfer_instruction_exec_tb.sv
// data_transfer_instruction_exec_tb: self-checking bench for dtx_exec
`timescale 1ns/1ps
module data_transfer_instruction_exec_tb;
  import dtx_pkg::*;
  localparam dtx_mode_t PL = DTX_AM_PLAIN, PI = DTX_AM_POST_INC, PD = DTX_AM_PRE_DEC;
  logic clk, rst, instr_valid, instr_ready, prog_rd, done, illegal, ill;
  dtx_instr_t instr;
  dtx_mem_req_t data_req;
  logic [7:0] data_rdata, prog_rdata, peek_data;
  logic [15:0] prog_addr, stack_ptr, a;
  logic [15:0] p[3];
  logic [7:0] r[32];
  logic [4:0] peek_idx;
  logic [5:0] d;
  logic [26:0] q[$];
  int miscompares, n_checks, cyc, k;
  dtx_exec dtx_exec_i(.clk, .rst, .instr_valid, .instr_ready, .instr, .data_req, .data_rdata, .prog_addr, .prog_rd,
    .prog_rdata, .done, .illegal, .stack_ptr, .peek_idx, .peek_data);
  dtx_mem_model dtx_mem_model_i(.clk, .data_req, .data_rdata, .prog_addr, .prog_rd, .prog_rdata);
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic chk(string n, logic [26:0] s, logic [26:0] x);
    n_checks++;
    if (s !== x) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic wrap_up;
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic go(dtx_op_t o, int pt, dtx_mode_t m, logic [4:0] ri, logic [5:0] dd, logic [15:0] ad);
    @(negedge clk);
    instr = '{o, dtx_ptr_t'(pt), m, ri, dd, ad};
    instr_valid = 1;
    peek_idx = 5'($urandom);
    @(negedge clk);
    instr_valid = 0;
    for (int i = 0; i < 6 && done !== 1'b1; i++) @(negedge clk);
    ill = illegal;
    if (peek_idx < 5'd26) chk("peek", 27'(peek_data), 27'(r[peek_idx]));
  endtask : go
  // note the expected transfer, then issue
  task automatic xf(dtx_op_t o, int pt, dtx_mode_t m, logic [4:0] ri, logic [5:0] dd, logic [15:0] ea);
    logic [2:0] kd;
    kd = o == DTX_OP_PROG_READ ? 3'h1 :
      o inside {DTX_OP_STORE, DTX_OP_DISP_STORE, DTX_OP_DIRECT_STORE, DTX_OP_PUSH} ? 3'h2 : 3'h4;
    q.push_back({kd, ea, kd[1] ? r[ri] : 8'h00});
    if (!kd[1]) r[ri] = ea[7:0] ^ ea[15:8] ^ (kd[0] ? 8'hA5 : 8'h00);
    go(o, pt, m, ri, dd, ea);
  endtask : xf
  always @(negedge clk) begin
    if (!rst && (data_req.rd || data_req.wr || prog_rd))
      chk("transfer", {data_req.rd, data_req.wr, prog_rd, prog_rd ? prog_addr : data_req.addr,
        data_req.wr ? data_req.wdata : 8'h00}, q.size() > 0 ? q.pop_front() : 27'h7FFFFFF);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 4000) begin
      miscompares++;
      wrap_up;
    end
  end
  initial begin
    void'($urandom(11));
    rst = 1;
    instr_valid = 0;
    instr = '0;
    peek_idx = 0;
    for (k = 0; k < 32; k++) r[k] = 8'h00;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 0;
    for (k = 0; k < 3; k++) begin
      a = (k == 0) ? 16'h00FF : 16'($urandom);
      xf(DTX_OP_DIRECT_LOAD, 0, PL, 5'(26 + 2 * k), 0, a);
      xf(DTX_OP_DIRECT_LOAD, 0, PL, 5'(27 + 2 * k), 0, 16'($urandom));
      p[k] = {r[27 + 2 * k], r[26 + 2 * k]};
      xf(DTX_OP_LOAD, k, PI, 5, 0, p[k]);
      p[k]++;
      xf(DTX_OP_STORE, k, PL, 5, 0, p[k]);
      p[k]--;
      xf(DTX_OP_STORE, k, PD, 5, 0, p[k]);
      p[k]--;
      xf(DTX_OP_LOAD, k, PD, 6, 0, p[k]);
      xf(DTX_OP_STORE, k, PI, 6, 0, p[k]);
      p[k]++;
    end
    go(DTX_OP_DISP_LOAD, 0, PL, 9, 1, 0);
    chk("illegal", 27'(ill), 27'h1);
    for (k = 1; k < 3; k++) begin
      d = 6'($urandom);
      xf(DTX_OP_DISP_LOAD, k, PL, 9, d, p[k] + 16'(d));
      xf(DTX_OP_DISP_STORE, k, PL, 9, 6'h3F - d, p[k] + 16'h003F - 16'(d));
      xf(DTX_OP_STORE, k, PL, 9, 0, p[k]);
    end
    xf(DTX_OP_DIRECT_STORE, 0, PL, 6, 0, 16'($urandom));
    xf(DTX_OP_PROG_READ, 2, PL, DTX_REG_ZERO, 0, p[2]);
    xf(DTX_OP_PROG_READ, 2, PI, 4, 0, p[2]);
    p[2]++;
    xf(DTX_OP_PROG_READ, 2, PL, 8, 0, p[2]);
    for (k = 0; k < 9; k += 4) xf(DTX_OP_DIRECT_STORE, 0, PL, 5'(k), 0, 16'($urandom));
    xf(DTX_OP_PUSH, 0, PL, 4, 0, DTX_SP_RESET);
    xf(DTX_OP_POP, 0, PL, 10, 0, DTX_SP_RESET);
    xf(DTX_OP_DIRECT_STORE, 0, PL, 10, 0, 16'($urandom));
    repeat (4) @(negedge clk);
    chk("pending", 27'(q.size()), 27'h0);
    wrap_up;
  end
endmodule : data_transfer_instruction_exec_tb

// file: testbench/dtx_exec_chk.sv
// dtx_exec_chk: port assertions for dtx_exec
`timescale 1ns/1ps
module dtx_exec_chk
  import dtx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire dtx_pkg::dtx_instr_t instr,
  input wire dtx_pkg::dtx_mem_req_t data_req,
  input wire logic prog_rd,
  input wire logic done,
  input wire logic illegal,
  input wire logic [15:0] stack_ptr
);
  logic tk;
  logic dx;
  assign tk = instr_valid && instr_ready;
  assign dx = instr.op inside {DTX_OP_DISP_LOAD, DTX_OP_DISP_STORE} && instr.ptr == DTX_PTR_SEL_X;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  load_timing_a: assert property (
    tk && !dx && instr.op inside {DTX_OP_LOAD, DTX_OP_DISP_LOAD, DTX_OP_DIRECT_LOAD, DTX_OP_POP}
    |=> ##1 data_req.rd && !data_req.wr && !done ##1 done) else $error("load timing");
  store_timing_a: assert property (
    tk && !dx && instr.op inside {DTX_OP_STORE, DTX_OP_DISP_STORE, DTX_OP_DIRECT_STORE, DTX_OP_PUSH}
    |=> ##1 data_req.wr && !data_req.rd && !done ##1 done) else $error("store timing");
  prog_timing_a: assert property (
    tk && instr.op == DTX_OP_PROG_READ |=> ##1 prog_rd && !data_req.rd ##1 !done ##1 done)
    else $error("program read timing");
  direct_addr_a: assert property (
    tk && instr.op inside {DTX_OP_DIRECT_LOAD, DTX_OP_DIRECT_STORE} |=> ##1 data_req.addr == $past(instr.addr, 2))
    else $error("direct address");
  disp_x_a: assert property (
    tk && dx |=> done && illegal && !data_req.rd && !data_req.wr) else $error("displaced through X");
  push_sp_a: assert property (
    tk && instr.op == DTX_OP_PUSH |=> ##1 data_req.addr == $past(stack_ptr, 2)
    && stack_ptr == $past(stack_ptr, 2) - 16'h0001)
    else $error("push stack");
  pop_sp_a: assert property (
    tk && instr.op == DTX_OP_POP |=> ##1 data_req.addr == $past(stack_ptr, 2) + 16'h0001
    && stack_ptr == $past(stack_ptr, 2) + 16'h0001) else $error("pop stack");
  sp_reset_a: assert property (
    @(posedge clk) disable iff (1'b0) rst |=> stack_ptr == DTX_SP_RESET && !done) else $error("reset stack");
endmodule : dtx_exec_chk
bind dtx_exec dtx_exec_chk dtx_exec_chk_i(.clk, .rst, .instr_valid, .instr_ready, .instr, .data_req, .prog_rd, .done,
  .illegal, .stack_ptr);

// file: testbench/dtx_mem_model.sv
// dtx_mem_model: data and program memory seen by dtx_exec
`timescale 1ns/1ps
module dtx_mem_model
  import dtx_pkg::*;
(
  input wire logic clk,
  input wire dtx_pkg::dtx_mem_req_t data_req,
  output logic [7:0] data_rdata,
  input wire logic [15:0] prog_addr,
  input wire logic prog_rd,
  output logic [7:0] prog_rdata
);
  logic [15:0] pa;
  logic pv;
  always_ff @(posedge clk) begin
    pv <= prog_rd;
    if (prog_rd) pa <= prog_addr;
  end
  // byte valid only in its slot, inverted otherwise; data answers during the read pulse
  assign data_rdata = data_req.rd ? data_req.addr[7:0] ^ data_req.addr[15:8] : ~(data_req.addr[7:0] ^ data_req.addr[15:8]);
  assign prog_rdata = pv ? pa[7:0] ^ pa[15:8] ^ 8'hA5 : ~(pa[7:0] ^ pa[15:8] ^ 8'hA5);
endmodule : dtx_mem_model
